/* cfg_decode_pkg.sv */
// Constants, types and field layouts for the configuration address decoder
package cfg_decode_pkg;

  // ----------------------------------------------------------------
  // Host I/O locations
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_ADDR_PORT = 16'h0cf8;
  localparam logic [15:0] IO_DATA_WIN = 16'h0cfc;
  localparam logic [3:0] BE_FULL = 4'hf;

  // ----------------------------------------------------------------
  // Address port layout and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PORT_RESET = 32'h00000000;
  localparam logic [31:0] DATA_WIN_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_PORT_MASK = 32'h80fffffc;
  localparam int ENABLE_BIT = 31;
  localparam int BUS_LSB = 16;
  localparam int DEV_LSB = 11;
  localparam int FN_LSB = 8;
  localparam int REG_LSB = 2;
  localparam logic [7:0] BUS_ZERO = 8'h00;
  localparam logic [4:0] DEV_LAST_INTERNAL = 5'h02;
  localparam logic [4:0] DEV_LAST_IDSEL = 5'h0f;
  localparam logic [2:0] FN_ONLY_INTERNAL = 3'h0;
  localparam logic [1:0] TYPE0_CODE = 2'h0;
  localparam logic [1:0] TYPE1_CODE = 2'h1;
  localparam logic [31:0] ABORT_DATA = 32'hffffffff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_INTERNAL = 3'h1,
    TGT_HUB_T0 = 3'h2,
    TGT_HUB_T1 = 3'h3,
    TGT_GFX_T0 = 3'h4,
    TGT_GFX_T1 = 3'h5,
    TGT_ABORT = 3'h6
  } cfg_target_t;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } io_req_t;

  typedef struct packed {
    cfg_target_t target;
    logic [31:0] addr;
    logic [2:0] intSel;
  } cfg_route_t;

  typedef struct packed {
    cfg_route_t route;
    logic write;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } cfg_cycle_t;

endpackage : cfg_decode_pkg

/* cfg_route_decode.sv */
// Combinational target and address-image decode of the address port
`timescale 1ns/1ps
module cfg_route_decode (
  input wire logic [31:0] addrPort,
  input wire logic [7:0] secBus,
  input wire logic [7:0] subBus,
  output cfg_decode_pkg::cfg_route_t route
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot select of a device line, zero when out of range
  function automatic logic [15:0] devOneHot(input logic [4:0] dev, input logic [4:0] last);
    logic [15:0] sel;
    sel = 16'h0000;
    if (dev <= last) begin
      sel = 16'h0001 << dev[3:0];
    end
    return sel;
  endfunction : devOneHot

  // Common low part: function, register and cycle type code
  function automatic logic [10:0] lowImage(input logic [31:0] a, input logic [1:0] code);
    return {a[cfg_decode_pkg::FN_LSB +: 3], a[cfg_decode_pkg::REG_LSB +: 6], code};
  endfunction : lowImage

  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] fn;
  logic [15:0] idsel;
  logic [15:0] intHot;

  assign bus = addrPort[cfg_decode_pkg::BUS_LSB +: 8];
  assign dev = addrPort[cfg_decode_pkg::DEV_LSB +: 5];
  assign fn = addrPort[cfg_decode_pkg::FN_LSB +: 3];
  assign idsel = devOneHot(dev, cfg_decode_pkg::DEV_LAST_IDSEL);
  // Internal select reuses the line decode, cut to the three devices
  assign intHot = devOneHot(dev, cfg_decode_pkg::DEV_LAST_INTERNAL);

  // ----------------------------------------------------------------
  // Route selection by bus number, then device number
  // ----------------------------------------------------------------
  always_comb begin
    route.target = cfg_decode_pkg::TGT_NONE;
    route.addr = 32'h00000000;
    route.intSel = 3'h0;
    if (bus == cfg_decode_pkg::BUS_ZERO) begin
      if (dev <= cfg_decode_pkg::DEV_LAST_INTERNAL) begin
        if (fn == cfg_decode_pkg::FN_ONLY_INTERNAL) begin
          route.target = cfg_decode_pkg::TGT_INTERNAL;
          route.intSel = intHot[2:0];
          route.addr = {21'h000000, lowImage(addrPort, cfg_decode_pkg::TYPE0_CODE)};
        end else begin
          route.target = cfg_decode_pkg::TGT_ABORT;
        end
      end else begin
        // Hub carries the device number itself on its address bits
        route.target = cfg_decode_pkg::TGT_HUB_T0;
        route.addr = {16'h0000, dev, lowImage(addrPort, cfg_decode_pkg::TYPE0_CODE)};
      end
    end else if (bus == secBus) begin
      // Devices above the last line get no IDSEL and master-abort
      route.target = cfg_decode_pkg::TGT_GFX_T0;
      route.addr = {idsel, 5'h00, lowImage(addrPort, cfg_decode_pkg::TYPE0_CODE)};
    end else if (bus > secBus && bus <= subBus) begin
      route.target = cfg_decode_pkg::TGT_GFX_T1;
      route.addr = {8'h00, bus, dev, lowImage(addrPort, cfg_decode_pkg::TYPE1_CODE)};
    end else begin
      route.target = cfg_decode_pkg::TGT_HUB_T1;
      route.addr = {8'h00, bus, dev, lowImage(addrPort, cfg_decode_pkg::TYPE1_CODE)};
    end
  end

endmodule : cfg_route_decode

/* config_address_decoder.sv */
// Host I/O configuration address port, data window and cycle router
`timescale 1ns/1ps
module config_address_decoder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ioReq,
  input wire cfg_decode_pkg::io_req_t ioCmd,
  output logic ioAck,
  output logic [31:0] ioRdata,
  output logic fwdReq,
  output cfg_decode_pkg::io_req_t fwdCmd,
  input wire logic fwdDone,
  input wire logic [31:0] fwdRdata,
  input wire logic [7:0] secBus,
  input wire logic [7:0] subBus,
  output logic cfgReq,
  output cfg_decode_pkg::cfg_cycle_t cfgCycle,
  input wire logic cfgDone,
  input wire logic [31:0] cfgRdata,
  input wire logic cfgMasterAbort,
  output logic gfxMasterAbort,
  output logic cfgEnable
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CFG = 2'h1,
    ST_FWD = 2'h2
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [31:0] addrPort_r;
  logic [31:0] ioRdata_r;
  logic ioAck_r;
  logic fwdReq_r;
  cfg_decode_pkg::io_req_t fwdCmd_r;
  logic cfgReq_r;
  cfg_decode_pkg::cfg_cycle_t cfgCycle_r;
  logic gfxMasterAbort_r;
  cfg_decode_pkg::cfg_route_t route;

  logic idle;
  logic hitAddr;
  logic hitWin;
  logic winOn;
  logic doAddr;
  logic doCfg;
  logic doAbort;
  logic doFwd;
  logic cfgEnd;
  logic fwdEnd;
  logic gfxTarget;

  // ----------------------------------------------------------------
  // Route decode of the current address port
  // ----------------------------------------------------------------
  cfg_route_decode u_route (
    .addrPort(addrPort_r),
    .secBus(secBus),
    .subBus(subBus),
    .route(route)
  );

  // ----------------------------------------------------------------
  // Request classification
  // ----------------------------------------------------------------
  // Requests arriving while busy are ignored; host waits for ack
  assign idle = (state_r == ST_IDLE);
  assign hitAddr = (ioCmd.addr[15:2] == cfg_decode_pkg::IO_ADDR_PORT[15:2]);
  assign hitWin = (ioCmd.addr[15:2] == cfg_decode_pkg::IO_DATA_WIN[15:2]);
  assign winOn = addrPort_r[cfg_decode_pkg::ENABLE_BIT];
  assign doAddr = ioReq && idle && hitAddr && (ioCmd.byteEn == cfg_decode_pkg::BE_FULL);
  assign doCfg = ioReq && idle && hitWin && winOn && (route.target != cfg_decode_pkg::TGT_ABORT);
  assign doAbort = ioReq && idle && hitWin && winOn && (route.target == cfg_decode_pkg::TGT_ABORT);
  // Partial port access, disabled window and foreign I/O all pass on
  assign doFwd = ioReq && idle && !doAddr && !doCfg && !doAbort;
  assign cfgEnd = (state_r == ST_CFG) && cfgDone;
  assign fwdEnd = (state_r == ST_FWD) && fwdDone;
  assign gfxTarget = (cfgCycle_r.route.target == cfg_decode_pkg::TGT_GFX_T0) ||
                     (cfgCycle_r.route.target == cfg_decode_pkg::TGT_GFX_T1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state from the classified request and completions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (doCfg) begin
          state_nxt = ST_CFG;
        end else if (doFwd) begin
          state_nxt = ST_FWD;
        end
      end
      ST_CFG: begin
        if (cfgDone) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FWD: begin
        if (fwdDone) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address port
  // ----------------------------------------------------------------
  // Reserved bits are masked at write so they always read zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addrPort_r <= cfg_decode_pkg::ADDR_PORT_RESET;
    end else if (doAddr && ioCmd.write) begin
      addrPort_r <= ioCmd.wdata & cfg_decode_pkg::ADDR_PORT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Host answer
  // ----------------------------------------------------------------
  // One-cycle ack for every request taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ioAck_r <= 1'b0;
    end else begin
      ioAck_r <= doAddr || doAbort || cfgEnd || fwdEnd;
    end
  end

  // Read data; holds the last port, window or forwarded read value between accesses
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ioRdata_r <= cfg_decode_pkg::DATA_WIN_RESET;
    end else if (doAddr && !ioCmd.write) begin
      ioRdata_r <= addrPort_r;
    end else if (doAbort && !ioCmd.write) begin
      ioRdata_r <= cfg_decode_pkg::ABORT_DATA;
    end else if (cfgEnd && !cfgCycle_r.write) begin
      ioRdata_r <= cfgMasterAbort ? cfg_decode_pkg::ABORT_DATA : cfgRdata;
    end else if (fwdEnd && !fwdCmd_r.write) begin
      ioRdata_r <= fwdRdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration cycle issue
  // ----------------------------------------------------------------
  // Request pulse; cycle fields hold until the next issue
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfgReq_r <= 1'b0;
    end else begin
      cfgReq_r <= doCfg;
    end
  end

  // Snapshot of route and host data at issue time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfgCycle_r <= '0;
    end else if (doCfg) begin
      cfgCycle_r.route <= route;
      cfgCycle_r.write <= ioCmd.write;
      cfgCycle_r.byteEn <= ioCmd.byteEn;
      cfgCycle_r.wdata <= ioCmd.wdata;
    end
  end

  // Graphics-side master abort reported to the bridge status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gfxMasterAbort_r <= 1'b0;
    end else begin
      gfxMasterAbort_r <= cfgEnd && cfgMasterAbort && gfxTarget;
    end
  end

  // ----------------------------------------------------------------
  // Expansion bus forwarding
  // ----------------------------------------------------------------
  // Original cycle passes unchanged, byte enables included
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fwdReq_r <= 1'b0;
    end else begin
      fwdReq_r <= doFwd;
    end
  end

  // Forwarded command held until the next forward
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fwdCmd_r <= '0;
    end else if (doFwd) begin
      fwdCmd_r <= ioCmd;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ioAck = ioAck_r;
  assign ioRdata = ioRdata_r;
  assign fwdReq = fwdReq_r;
  assign fwdCmd = fwdCmd_r;
  assign cfgReq = cfgReq_r;
  assign cfgCycle = cfgCycle_r;
  assign gfxMasterAbort = gfxMasterAbort_r;
  assign cfgEnable = addrPort_r[cfg_decode_pkg::ENABLE_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_window_req;
    ioReq && idle && hitWin && winOn;
  endsequence

  sequence s_cfg_finish;
    (state_r == ST_CFG) && cfgDone;
  endsequence

  sequence s_ack_pulse;
    ioAck_r ##1 !ioAck_r;
  endsequence

  a_reserved_bits_zero: assert property ((addrPort_r & ~cfg_decode_pkg::ADDR_PORT_MASK) == 32'h00000000)
    else $error("address port reserved bits not zero");

  a_full_write_loads: assert property (ioReq && idle && hitAddr && ioCmd.write &&
      (ioCmd.byteEn == cfg_decode_pkg::BE_FULL) |=>
      addrPort_r == ($past(ioCmd.wdata) & cfg_decode_pkg::ADDR_PORT_MASK) && ioAck_r && !fwdReq_r)
    else $error("full address port write not loaded");

  a_partial_passes: assert property (ioReq && idle && hitAddr &&
      (ioCmd.byteEn != cfg_decode_pkg::BE_FULL) |=>
      $stable(addrPort_r) && fwdReq_r && (fwdCmd_r == $past(ioCmd)))
    else $error("partial address port access not forwarded");

  a_window_translates: assert property (s_window_req |=> (cfgReq_r || ioAck_r) && !fwdReq_r)
    else $error("enabled window access not translated");

  a_window_disabled: assert property (ioReq && idle && hitWin && !winOn |=> fwdReq_r && !cfgReq_r)
    else $error("disabled window access translated");

  a_gfx_idsel_line: assert property (cfgReq_r && (cfgCycle_r.route.target == cfg_decode_pkg::TGT_GFX_T0) |->
      $onehot0(cfgCycle_r.route.addr[31:16]) && (cfgCycle_r.route.addr[15:11] == 5'h00) &&
      ((addrPort_r[15:11] > cfg_decode_pkg::DEV_LAST_IDSEL) == (cfgCycle_r.route.addr[31:16] == 16'h0000)))
    else $error("graphics type 0 idsel wrong");

  a_type1_fields: assert property (cfgReq_r && ((cfgCycle_r.route.target == cfg_decode_pkg::TGT_GFX_T1) ||
      (cfgCycle_r.route.target == cfg_decode_pkg::TGT_HUB_T1)) |->
      (cfgCycle_r.route.addr[23:2] == addrPort_r[23:2]) && (cfgCycle_r.route.addr[1:0] == 2'h1))
    else $error("type 1 address image wrong");

  a_internal_fn_zero: assert property (cfgReq_r && (cfgCycle_r.route.target == cfg_decode_pkg::TGT_INTERNAL) |->
      (addrPort_r[10:8] == 3'h0) && (addrPort_r[23:16] == 8'h00) && $onehot(cfgCycle_r.route.intSel))
    else $error("internal function selected with nonzero function");

  a_cfg_completes: assert property (s_cfg_finish |=> s_ack_pulse ##0 (state_r == ST_IDLE))
    else $error("configuration completion not acknowledged");

  a_gfx_abort_flag: assert property (s_cfg_finish ##0 cfgMasterAbort ##0 gfxTarget |=> gfxMasterAbort_r ##1 !gfxMasterAbort_r)
    else $error("graphics master abort not reported");

  // Short names for the issued cycle and the port fields behind it
  cfg_decode_pkg::cfg_target_t issuedTgt;
  logic [31:0] issuedAddr;
  logic [7:0] portBus;
  logic [4:0] portDev;

  assign issuedTgt = cfgCycle_r.route.target;
  assign issuedAddr = cfgCycle_r.route.addr;
  assign portBus = addrPort_r[cfg_decode_pkg::BUS_LSB +: 8];
  assign portDev = addrPort_r[cfg_decode_pkg::DEV_LSB +: 5];

  // Port cannot move while a cycle is open, so it still shows the source
  a_bus_zero_local: assert property (cfgReq_r && (portBus == cfg_decode_pkg::BUS_ZERO) |->
      (issuedTgt == cfg_decode_pkg::TGT_INTERNAL) || (issuedTgt == cfg_decode_pkg::TGT_HUB_T0))
    else $error("bus zero access left bus zero");

  a_hub_t0_image: assert property (cfgReq_r && (issuedTgt == cfg_decode_pkg::TGT_HUB_T0) |->
      (portDev > cfg_decode_pkg::DEV_LAST_INTERNAL) && (issuedAddr[31:16] == 16'h0000) &&
      (issuedAddr[15:11] == portDev) && (issuedAddr[1:0] == cfg_decode_pkg::TYPE0_CODE))
    else $error("hub type 0 image wrong");

  // Bridge numbers checked as they stood when the route was taken
  a_gfx_t0_bus: assert property (cfgReq_r && (issuedTgt == cfg_decode_pkg::TGT_GFX_T0) |->
      (portBus != cfg_decode_pkg::BUS_ZERO) && (portBus == $past(secBus)))
    else $error("graphics type 0 on wrong bus");

  a_gfx_t1_range: assert property (cfgReq_r && (issuedTgt == cfg_decode_pkg::TGT_GFX_T1) |->
      (portBus > $past(secBus)) && (portBus <= $past(subBus)))
    else $error("graphics type 1 outside bridge range");

  a_hub_t1_range: assert property (cfgReq_r && (issuedTgt == cfg_decode_pkg::TGT_HUB_T1) |->
      (portBus != cfg_decode_pkg::BUS_ZERO) && ((portBus < $past(secBus)) || (portBus > $past(subBus))))
    else $error("hub type 1 inside bridge range");

  a_idsel_position: assert property (cfgReq_r && (issuedTgt == cfg_decode_pkg::TGT_GFX_T0) &&
      (portDev <= cfg_decode_pkg::DEV_LAST_IDSEL) |-> issuedAddr[31:16] == (16'h0001 << portDev[3:0]))
    else $error("graphics select on wrong line");

  a_low_fields: assert property (cfgReq_r |-> issuedAddr[10:2] == addrPort_r[10:2])
    else $error("function or register field lost");

  // Enable must have stood when the window access was taken
  a_cfg_needs_enable: assert property (cfgReq_r |-> $past(winOn))
    else $error("configuration cycle with port disabled");

  // A pass-through must never disturb the port
  a_fwd_keeps_port: assert property (fwdReq_r |-> $stable(addrPort_r))
    else $error("forwarded access changed the port");

endmodule : config_address_decoder

/* cfg_far_model.sv */
// Far-side responders for configuration cycles and forwarded I/O cycles
`timescale 1ns/1ps
module cfg_far_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] lag,
  input wire logic cfgReq,
  input wire cfg_decode_pkg::cfg_cycle_t cfgCycle,
  output logic cfgDone,
  output logic [31:0] cfgRdata,
  output logic cfgMasterAbort,
  input wire logic fwdReq,
  input wire cfg_decode_pkg::io_req_t fwdCmd,
  output logic fwdDone,
  output logic [31:0] fwdRdata
);
  logic [3:0] cfgCnt_r;
  logic [3:0] fwdCnt_r;
  logic noSel;

  // A graphics Type 0 cycle without any select line finds no target
  assign noSel = (cfgCycle.route.target == cfg_decode_pkg::TGT_GFX_T0) && (cfgCycle.route.addr[31:16] == 16'h0000);

  // Config target; data lines toggle outside the answer so stale values never match
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfgCnt_r <= 4'h0;
      cfgDone <= 1'b0;
      cfgRdata <= 32'h00000000;
      cfgMasterAbort <= 1'b0;
    end else begin
      cfgDone <= (cfgCnt_r == 4'h1);
      if (cfgReq) begin
        cfgCnt_r <= {1'b0, lag} + 4'h1;
      end else if (cfgCnt_r != 4'h0) begin
        cfgCnt_r <= cfgCnt_r - 4'h1;
      end
      if (cfgCnt_r == 4'h1) begin
        cfgRdata <= noSel ? 32'hffffffff : (cfgCycle.route.addr ^ 32'h5a5a5a5a);
        cfgMasterAbort <= noSel;
      end else begin
        cfgRdata <= ~cfgRdata;
        cfgMasterAbort <= 1'b0;
      end
    end
  end

  // Expansion bus target for passed-through I/O cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fwdCnt_r <= 4'h0;
      fwdDone <= 1'b0;
      fwdRdata <= 32'h00000000;
    end else begin
      fwdDone <= (fwdCnt_r == 4'h1);
      if (fwdReq) begin
        fwdCnt_r <= {1'b0, lag} + 4'h1;
      end else if (fwdCnt_r != 4'h0) begin
        fwdCnt_r <= fwdCnt_r - 4'h1;
      end
      fwdRdata <= (fwdCnt_r == 4'h1) ? ({16'h0000, fwdCmd.addr} ^ 32'hc3c3c3c3) : ~fwdRdata;
    end
  end
endmodule : cfg_far_model

/* tb_top.sv */
// Self-checking bench for the configuration address decoder
`timescale 1ns/1ps
module tb_top;
  logic clk_sys;
  logic nrst;
  logic ioReq;
  cfg_decode_pkg::io_req_t ioCmd;
  logic ioAck;
  logic [31:0] ioRdata;
  logic fwdReq;
  cfg_decode_pkg::io_req_t fwdCmd;
  logic fwdDone;
  logic [31:0] fwdRdata;
  logic [7:0] secBus;
  logic [7:0] subBus;
  logic cfgReq;
  cfg_decode_pkg::cfg_cycle_t cfgCycle;
  logic cfgDone;
  logic [31:0] cfgRdata;
  logic cfgMasterAbort;
  logic gfxMasterAbort;
  logic cfgEnable;
  logic [2:0] lag;
  int seed = 11;
  int bad_count = 0;
  int check_count = 0;
  logic sawCfg, sawFwd, sawGa;
  logic [31:0] gotRd;
  cfg_decode_pkg::cfg_cycle_t gotCyc;
  cfg_decode_pkg::io_req_t gotFwd;

  config_address_decoder dut_u (.clk_sys(clk_sys), .nrst(nrst), .ioReq(ioReq), .ioCmd(ioCmd), .ioAck(ioAck),
    .ioRdata(ioRdata), .fwdReq(fwdReq), .fwdCmd(fwdCmd), .fwdDone(fwdDone), .fwdRdata(fwdRdata),
    .secBus(secBus), .subBus(subBus), .cfgReq(cfgReq), .cfgCycle(cfgCycle), .cfgDone(cfgDone),
    .cfgRdata(cfgRdata), .cfgMasterAbort(cfgMasterAbort), .gfxMasterAbort(gfxMasterAbort), .cfgEnable(cfgEnable));

  cfg_far_model far_u (.clk_sys(clk_sys), .nrst(nrst), .lag(lag), .cfgReq(cfgReq), .cfgCycle(cfgCycle),
    .cfgDone(cfgDone), .cfgRdata(cfgRdata), .cfgMasterAbort(cfgMasterAbort), .fwdReq(fwdReq),
    .fwdCmd(fwdCmd), .fwdDone(fwdDone), .fwdRdata(fwdRdata));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Expected routing worked out from the address port fields
  function automatic cfg_decode_pkg::cfg_route_t exp_route(logic [31:0] a, logic [7:0] s, logic [7:0] u);
    cfg_decode_pkg::cfg_route_t r;
    logic [7:0] bus;
    bus = a[23:16];
    r = '0;
    if (bus == 8'h00 && a[15:11] <= 5'h02) begin
      r.target = (a[10:8] == 3'h0) ? cfg_decode_pkg::TGT_INTERNAL : cfg_decode_pkg::TGT_ABORT;
      r.addr = {21'h000000, a[10:2], 2'h0};
      r.intSel = 3'h1 << a[12:11];
    end else if (bus == 8'h00) begin
      r.target = cfg_decode_pkg::TGT_HUB_T0;
      r.addr = {16'h0000, a[15:2], 2'h0};
    end else if (bus == s) begin
      r.target = cfg_decode_pkg::TGT_GFX_T0;
      r.addr = {21'h000000, a[10:2], 2'h0};
      if (a[15:11] <= 5'h0f) r.addr[16 + a[14:11]] = 1'b1;
    end else begin
      r.target = (bus > s && bus <= u) ? cfg_decode_pkg::TGT_GFX_T1 : cfg_decode_pkg::TGT_HUB_T1;
      r.addr = {8'h00, a[23:2], 2'h1};
    end
    return r;
  endfunction : exp_route

  // One host I/O transfer; records what the far side saw
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    sawCfg = 1'b0;
    sawFwd = 1'b0;
    sawGa = 1'b0;
    @(posedge clk_sys);
    ioReq <= 1'b1;
    ioCmd <= '{wr, a, be, wd};
    lag <= 3'($random(seed));
    @(posedge clk_sys);
    ioReq <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
      if (cfgReq === 1'b1) begin
        sawCfg = 1'b1;
        gotCyc = cfgCycle;
      end
      if (fwdReq === 1'b1) begin
        sawFwd = 1'b1;
        gotFwd = fwdCmd;
      end
      if (gfxMasterAbort === 1'b1) sawGa = 1'b1;
    end while (ioAck !== 1'b1 && n < 100);
    if (n >= 100) chk(1'b0, 1'b1);
    gotRd = ioRdata;
  endtask : io

  // Pass-through check of a plain I/O cycle
  task automatic fwd_chk(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
    io(wr, a, be, wd);
    chk({sawFwd, sawCfg, gotFwd}, {2'b10, wr, a, be, wd});
    if (!wr) chk(gotRd, {16'h0000, a} ^ 32'hc3c3c3c3);
  endtask : fwd_chk

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end

  // Main sequence: fixed corner cases, then random routing
  initial begin
    logic [31:0] r, a, w;
    cfg_decode_pkg::cfg_route_t e;
    logic ns;
    nrst = 1'b0;
    ioReq = 1'b0;
    ioCmd = '0;
    secBus = 8'h01;
    subBus = 8'h01;
    lag = 3'h0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    io(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'h0);
    chk({gotRd, cfgEnable}, 33'h0);
    fwd_chk(1'b0, cfg_decode_pkg::IO_DATA_WIN, 4'hf, 32'h0);
    fwd_chk(1'b1, cfg_decode_pkg::IO_DATA_WIN, 4'h3, 32'h1234abcd);
    io(1'b1, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'hffffffff);
    chk(cfgEnable, 1'b1);
    io(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'h0);
    chk(gotRd, 32'h80fffffc);
    fwd_chk(1'b1, cfg_decode_pkg::IO_ADDR_PORT, 4'h1, 32'h0);
    fwd_chk(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hc, 32'h0);
    fwd_chk(1'b0, 16'h0080, 4'hf, 32'h0);
    io(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'h0);
    chk(gotRd, 32'h80fffffc);
    for (int i = 0; i < 150; i++) begin
      r = $random(seed);
      w = $random(seed);
      secBus <= {1'b0, r[6:0]} | 8'h01;
      subBus <= ({1'b0, r[6:0]} | 8'h01) + {5'h00, r[10:8]};
      a = {1'b1, 7'h00, 8'h00, r[20] ? {3'h0, r[22:21] % 2'h3} : r[25:21], r[26] ? 3'h0 : w[2:0], w[8:3], 2'h0};
      case (r[13:12])
        2'h0: a[23:16] = 8'h00;
        2'h1: a[23:16] = {1'b0, r[6:0]} | 8'h01;
        2'h2: a[23:16] = ({1'b0, r[6:0]} | 8'h01) + {5'h00, r[17:15]};
        default: a[23:16] = r[31:24];
      endcase
      io(1'b1, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, a | {1'b0, w[15:9], 22'h0, w[17:16]});
      io(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'h0);
      chk(gotRd, a);
      e = exp_route(a, secBus, subBus);
      ns = (e.target == cfg_decode_pkg::TGT_GFX_T0) && (a[15:11] > 5'h0f);
      io(w[18], cfg_decode_pkg::IO_DATA_WIN, w[22:19] | 4'h1, r);
      chk(sawFwd, 1'b0);
      if (e.target == cfg_decode_pkg::TGT_ABORT) begin
        chk(sawCfg, 1'b0);
        if (!w[18]) chk(gotRd, cfg_decode_pkg::ABORT_DATA);
      end else begin
        chk(sawCfg, 1'b1);
        chk(gotCyc.route.target, e.target);
        chk(gotCyc.route.addr, e.addr);
        if (e.target == cfg_decode_pkg::TGT_INTERNAL) chk(gotCyc.route.intSel, e.intSel);
        chk({gotCyc.write, gotCyc.byteEn, gotCyc.wdata}, {w[18], w[22:19] | 4'h1, r});
        if (!w[18]) chk(gotRd, ns ? 32'hffffffff : (e.addr ^ 32'h5a5a5a5a));
        chk(sawGa, ns);
      end
    end
    // Mid-run reset: port, enable and window data fall back to zero
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({ioRdata, cfgEnable, ioAck, cfgReq, fwdReq}, 36'h0);
    nrst <= 1'b1;
    io(1'b0, cfg_decode_pkg::IO_ADDR_PORT, 4'hf, 32'h0);
    chk({gotRd, cfgEnable}, 33'h0);
    test_done();
  end
endmodule : tb_top
